// file: logic/time_base_irq.sv
// periodic time base interrupt generator with apb register access
//
// Overview of operation
// R1: control register at index 0x39, bits 7..4 read zero, all reset to zero.
// R2: control bit 3 enables interrupt requests; zero suppresses them all.
// R3: gear source rate codes select divide by 2^22,20,15,13,12,11,10,8.
// R4: low source codes 0..6 divide 2^15..2^3; 7 reserved; slow allows 0,1.
// R5: stop mode entry clears enable and keeps the rate field.
// R6: software changes the rate only while enable is zero.
// R7: every falling edge of the selected tap requests while enabled.
// R8: divider chain runs regardless of enable; enabling never restarts it.
// R9: first request comes at next tap falling edge, possibly short.
// R10: software switches normal and slow modes only while enable is zero.
// R11: low source in normal mode is resynchronised, so timing may jitter.
// R12: one periodic interrupt output gives software a regular time base.
// R13: each request is a one-cycle pulse from synchronised falling edge detection.
`timescale 1ns/1ns
module time_base_irq (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// apb slave
	input wire time_base_pkg::apb_req_t apb_req,
	output time_base_pkg::apb_rsp_t apb_rsp,
	// system side
	input wire logic low_freq_clock,
	input wire logic stop_entry,
	// interrupt outputs
	output logic periodic_irq,
	output logic irq
);

	time_base_pkg::state_t st_r;
	time_base_pkg::state_t st_nxt;
	logic use_lf;
	logic [4:0] exp_sel;
	logic [4:0] tap_idx;
	logic tap;
	logic setup;
	logic access;
	logic mapped;
	logic [31:0] rd_data;
	logic wr_ctrl;

	always_comb begin
		st_nxt = st_r;

		// low clock resync, first stage feeds only the second
		st_nxt.lf_sync1 = low_freq_clock; // [R11]
		st_nxt.lf_sync2 = st_r.lf_sync1;
		st_nxt.lf_prev = st_r.lf_sync2;
		if (st_r.lf_sync2 && !st_r.lf_prev) begin
			st_nxt.lf_cnt = st_r.lf_cnt + 15'h0001; // [R8]
		end
		st_nxt.gear_cnt = st_r.gear_cnt + 22'h000001; // [R8]

		// tap selection
		use_lf = st_r.sysc.lf_sel | st_r.sysc.slow;
		if (use_lf) begin
			exp_sel = time_base_pkg::LF_EXP[st_r.ctrl.rate]; // [R4]
		end else begin
			exp_sel = time_base_pkg::GEAR_EXP[st_r.ctrl.rate]; // [R3]
		end
		if (st_r.sysc.slow && (st_r.ctrl.rate > time_base_pkg::SLOW_MAX_RATE)) begin
			exp_sel = 5'd0; // [R4]
		end
		tap_idx = exp_sel - 5'd1;
		if (exp_sel == 5'd0) begin
			tap = 1'b0;
		end else if (use_lf) begin
			tap = st_r.lf_cnt[tap_idx[3:0]];
		end else begin
			tap = st_r.gear_cnt[tap_idx];
		end
		st_nxt.tap_prev = tap;

		// request on falling tap edge while enabled
		st_nxt.pulse = st_r.ctrl.en && st_r.tap_prev && !tap; // [R2] [R7] [R9] [R13]

		// apb decode
		setup = apb_req.psel && !apb_req.penable;
		access = apb_req.psel && apb_req.penable && st_r.rsp.pready;
		mapped = 1'b1;
		rd_data = 32'h00000000;
		case (apb_req.paddr)
			time_base_pkg::CTRL_ADDR: begin
				rd_data[3:0] = st_r.ctrl; // [R1]
			end
			time_base_pkg::SYSC_ADDR: begin
				rd_data[1:0] = st_r.sysc;
			end
			time_base_pkg::STAT_ADDR: begin
				rd_data[time_base_pkg::STAT_TICK_BIT] = st_r.status;
			end
			time_base_pkg::MASK_ADDR: begin
				rd_data[time_base_pkg::STAT_TICK_BIT] = st_r.mask;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase

		// register writes at the access edge
		wr_ctrl = access && apb_req.pwrite && (apb_req.paddr == time_base_pkg::CTRL_ADDR);
		if (wr_ctrl) begin
			st_nxt.ctrl.en = apb_req.pwdata[time_base_pkg::CTRL_EN_BIT]; // [R2]
			st_nxt.ctrl.rate = apb_req.pwdata[time_base_pkg::CTRL_RATE_LSB +: 3];
		end
		if (access && apb_req.pwrite && (apb_req.paddr == time_base_pkg::SYSC_ADDR)) begin
			st_nxt.sysc.lf_sel = apb_req.pwdata[time_base_pkg::SYSC_LF_SEL_BIT];
			st_nxt.sysc.slow = apb_req.pwdata[time_base_pkg::SYSC_SLOW_BIT];
		end
		if (access && apb_req.pwrite && (apb_req.paddr == time_base_pkg::MASK_ADDR)) begin
			st_nxt.mask = apb_req.pwdata[time_base_pkg::STAT_TICK_BIT];
		end
		if (access && apb_req.pwrite && (apb_req.paddr == time_base_pkg::STAT_ADDR)
				&& apb_req.pwdata[time_base_pkg::STAT_TICK_BIT]) begin
			st_nxt.status = 1'b0;
		end

		// stop entry clears enable, rate kept
		if (stop_entry) begin
			st_nxt.ctrl.en = 1'b0; // [R5]
		end

		// sticky event, set wins over clear
		if (st_nxt.pulse) begin
			st_nxt.status = 1'b1;
		end
		st_nxt.irq = st_nxt.status & st_nxt.mask;

		// apb answer, zero wait states
		if (setup) begin
			st_nxt.rsp.pready = 1'b1;
			st_nxt.rsp.pslverr = !mapped;
			st_nxt.rsp.prdata = apb_req.pwrite ? 32'h00000000 : rd_data;
		end else if (access) begin
			st_nxt.rsp.pready = 1'b0;
			st_nxt.rsp.pslverr = 1'b0;
			st_nxt.rsp.prdata = 32'h00000000;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			st_r <= '0; // [R1]
			st_r.ctrl <= time_base_pkg::CTRL_RESET;
			st_r.sysc <= time_base_pkg::SYSC_RESET;
			st_r.status <= time_base_pkg::STAT_RESET;
			st_r.mask <= time_base_pkg::MASK_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign apb_rsp = st_r.rsp;
	assign periodic_irq = st_r.pulse; // [R12]
	assign irq = st_r.irq;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	ctrl_read_zero_a: assert property ( // [R1]
		(apb_req.psel && apb_req.penable && apb_rsp.pready && !apb_req.pwrite
			&& apb_req.paddr == time_base_pkg::CTRL_ADDR)
		|-> (apb_rsp.prdata[31:4] == 28'h0000000
			&& apb_rsp.prdata[3:0] == st_r.ctrl))
		else $error("control read shows wrong bits");

	enable_gate_a: assert property ( // [R2]
		periodic_irq |-> $past(st_r.ctrl.en))
		else $error("request while enable was clear");

	gear_tap_a: assert property ( // [R3]
		($fell(st_r.gear_cnt[7]) && st_r.ctrl.en && st_r.ctrl.rate == 3'h7
			&& !st_r.sysc.lf_sel && !st_r.sysc.slow)
		|=> periodic_irq)
		else $error("gear tap falling edge missed");

	lf_tap_a: assert property ( // [R4]
		($fell(st_r.lf_cnt[2]) && st_r.ctrl.en && st_r.ctrl.rate == 3'h6
			&& st_r.sysc.lf_sel && !st_r.sysc.slow)
		|=> periodic_irq)
		else $error("low clock tap falling edge missed");

	slow_reserved_a: assert property ( // [R4]
		(st_r.sysc.slow && st_r.ctrl.rate > 3'h1) [*2] |=> !periodic_irq)
		else $error("request on reserved slow rate");

	stop_clear_a: assert property ( // [R5]
		stop_entry |=> (!st_r.ctrl.en && st_r.ctrl.rate == $past(st_r.ctrl.rate)))
		else $error("stop entry did not clear enable");

	divider_free_a: assert property ( // [R8]
		(apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite)
		|=> st_r.gear_cnt == $past(st_r.gear_cnt) + 22'h000001)
		else $error("divider disturbed by register write");

	pulse_single_a: assert property ( // [R13]
		periodic_irq |=> !periodic_irq)
		else $error("request longer than one cycle");

	irq_level_a: assert property (
		irq == (st_r.status & st_r.mask))
		else $error("interrupt level mismatch");

	status_sticky_a: assert property (
		periodic_irq |-> st_r.status)
		else $error("event did not set status");

	setup_ready_a: assert property (
		(apb_req.psel && !apb_req.penable) |=> apb_rsp.pready)
		else $error("no ready after setup cycle");

	ready_single_a: assert property (
		apb_rsp.pready |=> !apb_rsp.pready)
		else $error("ready held longer than one cycle");

	unmapped_err_a: assert property (
		(apb_req.psel && apb_req.penable && apb_rsp.pready
			&& apb_req.paddr[11:8] != 4'h0)
		|-> (apb_rsp.pslverr && apb_rsp.prdata == 32'h00000000))
		else $error("unmapped access not flagged");

	mapped_ok_a: assert property (
		(apb_req.psel && apb_req.penable && apb_rsp.pready
			&& apb_req.paddr == time_base_pkg::CTRL_ADDR)
		|-> !apb_rsp.pslverr)
		else $error("error flagged on control register");

	ctrl_write_a: assert property ( // [R2]
		(apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
			&& apb_req.paddr == time_base_pkg::CTRL_ADDR && !stop_entry)
		|=> (st_r.ctrl == $past(apb_req.pwdata[3:0])))
		else $error("control write did not land");

	stop_quiet_a: assert property ( // [R5]
		stop_entry |-> ##2 !periodic_irq)
		else $error("request after stop entry");

	gear_slow_tap_a: assert property ( // [R3]
		($fell(st_r.gear_cnt[12]) && st_r.ctrl.en && st_r.ctrl.rate == 3'h3
			&& !st_r.sysc.lf_sel && !st_r.sysc.slow)
		|=> periodic_irq)
		else $error("gear rate three tap missed");

	gear_quiet_a: assert property ( // [R7]
		(st_r.ctrl.en && st_r.ctrl.rate == 3'h7 && $stable(st_r.ctrl.rate) && $stable(st_r.sysc)
			&& !st_r.sysc.lf_sel && !st_r.sysc.slow && !$fell(st_r.gear_cnt[7]))
		|=> !periodic_irq)
		else $error("gear request without tap falling edge");

	status_clear_a: assert property (
		(apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
			&& apb_req.paddr == time_base_pkg::STAT_ADDR && apb_req.pwdata[0])
		|=> (st_r.status == periodic_irq))
		else $error("status clear or set priority wrong");

	mask_write_a: assert property (
		(apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
			&& apb_req.paddr == time_base_pkg::MASK_ADDR)
		|=> (st_r.mask == $past(apb_req.pwdata[time_base_pkg::STAT_TICK_BIT])))
		else $error("mask write did not land");

	lf_step_a: assert property ( // [R11]
		(st_r.lf_cnt != $past(st_r.lf_cnt))
		|-> (st_r.lf_cnt == $past(st_r.lf_cnt) + 15'h0001))
		else $error("low clock counter skipped");

	sysc_read_a: assert property (
		(apb_req.psel && apb_req.penable && apb_rsp.pready && !apb_req.pwrite
			&& apb_req.paddr == time_base_pkg::SYSC_ADDR)
		|-> (apb_rsp.prdata[31:2] == 30'h00000000))
		else $error("system control read shows stray bits");

	write_data_zero_a: assert property (
		(apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite)
		|-> (apb_rsp.prdata == 32'h00000000))
		else $error("read data not zero on write");

	lf_quiet_a: assert property ( // [R7]
		(st_r.ctrl.en && st_r.ctrl.rate == 3'h6 && $stable(st_r.ctrl.rate) && $stable(st_r.sysc)
			&& st_r.sysc.lf_sel && !st_r.sysc.slow && !$fell(st_r.lf_cnt[2]))
		|=> !periodic_irq)
		else $error("low clock request without tap falling edge");

	lf_reserved_a: assert property ( // [R4]
		(st_r.sysc.lf_sel && st_r.ctrl.rate == 3'h7) [*2] |=> !periodic_irq)
		else $error("request on reserved low clock rate");

	irq_follow_a: assert property ( // [R12]
		(periodic_irq && st_r.mask) |-> irq)
		else $error("unmasked request did not raise interrupt");

	ctrl_write_c: cover property (
		apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
		&& apb_req.paddr == time_base_pkg::CTRL_ADDR);
	gear_pulse_c: cover property (periodic_irq && !st_r.sysc.lf_sel);
	lf_pulse_c: cover property (periodic_irq && st_r.sysc.lf_sel);
	stop_c: cover property (stop_entry && st_r.ctrl.en);
	irq_raise_c: cover property ($rose(irq));

endmodule : time_base_irq

// file: logic/time_base_pkg.sv
// constants and types of the periodic time base interrupt block
package time_base_pkg;

	// register indices, byte address is four times the index
	localparam logic [9:0] CTRL_IDX = 10'h039;
	localparam logic [9:0] SYSC_IDX = 10'h03a;
	localparam logic [9:0] STAT_IDX = 10'h03b;
	localparam logic [9:0] MASK_IDX = 10'h03c;
	localparam logic [11:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
	localparam logic [11:0] SYSC_ADDR = {SYSC_IDX, 2'b00};
	localparam logic [11:0] STAT_ADDR = {STAT_IDX, 2'b00};
	localparam logic [11:0] MASK_ADDR = {MASK_IDX, 2'b00};

	// field positions
	localparam int CTRL_EN_BIT = 3;
	localparam int CTRL_RATE_LSB = 0;
	localparam int SYSC_LF_SEL_BIT = 0;
	localparam int SYSC_SLOW_BIT = 1;
	localparam int STAT_TICK_BIT = 0;

	// reset values
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [1:0] SYSC_RESET = 2'h0;
	localparam logic STAT_RESET = 1'b0;
	localparam logic MASK_RESET = 1'b0;

	// divider chain widths
	localparam int GEAR_W = 22;
	localparam int LF_W = 15;

	// divide exponents per rate code, code 0 at index 0, 0 marks reserved
	localparam logic [7:0][4:0] GEAR_EXP = {5'd8, 5'd10, 5'd11, 5'd12, 5'd13, 5'd15, 5'd20, 5'd22};
	localparam logic [7:0][4:0] LF_EXP = {5'd0, 5'd3, 5'd4, 5'd5, 5'd6, 5'd8, 5'd13, 5'd15};
	localparam logic [2:0] SLOW_MAX_RATE = 3'h1;

	typedef struct packed {
		logic en;
		logic [2:0] rate;
	} ctrl_t;

	typedef struct packed {
		logic slow;
		logic lf_sel;
	} sysc_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

	typedef struct packed {
		logic lf_sync1;
		logic lf_sync2;
		logic lf_prev;
		logic [LF_W-1:0] lf_cnt;
		logic [GEAR_W-1:0] gear_cnt;
		logic tap_prev;
		ctrl_t ctrl;
		sysc_t sysc;
		logic status;
		logic mask;
		logic irq;
		logic pulse;
		apb_rsp_t rsp;
	} state_t;

endpackage : time_base_pkg

// file: tb/tb_top.sv
// self-checking bench for the periodic time base interrupt block
`timescale 1ns/1ns
module tb_top;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic low_freq_clock = 1'b0;
	logic stop_entry = 1'b0;
	logic periodic_irq;
	logic irq;
	logic [2:0] lf_div = 3'h0;
	time_base_pkg::apb_req_t req = '0;
	time_base_pkg::apb_rsp_t rsp;
	int n_errors = 0;
	int comparisons = 0;
	int cyc = 0;
	int f;
	int n;
	logic [31:0] q;
	logic e;
	int gexp[5] = '{13, 12, 11, 10, 8};
	int lexp[4] = '{6, 5, 4, 3};

	time_base_irq i_time_base_irq (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.apb_req(req),
		.apb_rsp(rsp),
		.low_freq_clock(low_freq_clock),
		.stop_entry(stop_entry),
		.periodic_irq(periodic_irq),
		.irq(irq)
	);

	always #10 clk_sys = ~clk_sys;

	// low clock of eight system cycles, plus run limit
	always @(posedge clk_sys) begin
		lf_div <= lf_div + 3'h1;
		low_freq_clock <= lf_div[2];
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			n_errors++;
			$display("MISMATCH %0t got %h expected %h", $time, s, x);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk_sys);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge clk_sys);
		req.penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			t++;
		end while (rsp.pready !== 1'b1 && t < 50);
		if (rsp.pready !== 1'b1) n_errors++;
		q = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	// cycles to first pulse, then cycles between pulses, -1 if none
	task automatic gap(input int lim);
		f = 0;
		n = -1;
		do begin
			@(negedge clk_sys);
			f++;
		end while (periodic_irq !== 1'b1 && f < lim);
		if (periodic_irq === 1'b1) begin
			n = 0;
			do begin
				@(negedge clk_sys);
				n++;
			end while (periodic_irq !== 1'b1 && n < lim);
		end
	endtask : gap

	task tally_and_finish;
		if (n_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		apb(0, time_base_pkg::CTRL_ADDR, 0); chk(q, 32'h0);
		apb(0, time_base_pkg::STAT_ADDR, 0); chk(q, 32'h0);
		apb(1, time_base_pkg::CTRL_ADDR, 32'hff);
		apb(0, time_base_pkg::CTRL_ADDR, 0); chk(q, 32'h0f);
		@(posedge clk_sys);
		stop_entry <= 1'b1;
		@(posedge clk_sys);
		stop_entry <= 1'b0;
		apb(0, time_base_pkg::CTRL_ADDR, 0); chk(q, 32'h07);
		gap(600); chk(n, -1);
		apb(0, 12'h100, 0); chk({e, q[30:0]}, 32'h80000000);
		for (int i = 0; i < 5; i++) begin
			apb(1, time_base_pkg::CTRL_ADDR, 32'h3 + i);
			apb(1, time_base_pkg::CTRL_ADDR, 32'hb + i);
			gap(9000); chk(n, 1 << gexp[i]);
			apb(1, time_base_pkg::CTRL_ADDR, 32'h3 + i);
		end
		apb(0, time_base_pkg::STAT_ADDR, 0); chk(q, 32'h1);
		chk(irq, 1'b0);
		apb(1, time_base_pkg::MASK_ADDR, 32'h1);
		apb(0, time_base_pkg::MASK_ADDR, 0); chk(q, 32'h1);
		repeat (2) @(negedge clk_sys);
		chk(irq, 1'b1);
		apb(1, time_base_pkg::CTRL_ADDR, 32'h7);
		apb(1, time_base_pkg::STAT_ADDR, 32'h1);
		apb(0, time_base_pkg::STAT_ADDR, 0); chk(q, 32'h0);
		repeat (2) @(negedge clk_sys);
		chk(irq, 1'b0);
		for (int i = 0; i < 2; i++) begin
			repeat (100 + 37 * i) @(posedge clk_sys);
			apb(1, time_base_pkg::CTRL_ADDR, 32'hf);
			gap(600); chk(f < 256, 1'b1); chk(n, 256);
			apb(1, time_base_pkg::CTRL_ADDR, 32'h7);
		end
		apb(1, time_base_pkg::SYSC_ADDR, 32'h1);
		apb(0, time_base_pkg::SYSC_ADDR, 0); chk(q, 32'h1);
		for (int i = 0; i < 4; i++) begin
			apb(1, time_base_pkg::CTRL_ADDR, 32'h3 + i);
			apb(1, time_base_pkg::CTRL_ADDR, 32'hb + i);
			gap(1200); chk(n, 8 << lexp[i]);
			apb(1, time_base_pkg::CTRL_ADDR, 32'h3 + i);
		end
		apb(1, time_base_pkg::CTRL_ADDR, 32'h7);
		apb(1, time_base_pkg::CTRL_ADDR, 32'hf);
		gap(300); chk(n, -1);
		apb(1, time_base_pkg::CTRL_ADDR, 32'h2);
		apb(1, time_base_pkg::SYSC_ADDR, 32'h3);
		apb(1, time_base_pkg::CTRL_ADDR, 32'ha);
		gap(300); chk(n, -1);
		apb(0, time_base_pkg::SYSC_ADDR, 0); chk(q, 32'h3);
		tally_and_finish();
	end
endmodule : tb_top
